//--- rtl/i2c_csp_pkg.sv
// Purpose: Shared constants for the two-wire bus control, status and prescaler block
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   Divider helpers are used by the serial timer; the register logic only stores the codes
package i2c_csp_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_PRS      = 8'h04;
   localparam logic [7:0] OFF_SCK      = 8'h08;
   localparam logic [7:0] OFF_DATA     = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

   // Control view / status view bit positions
   localparam int B_ROLE  = 7;
   localparam int B_DIR   = 6;
   localparam int B_COND  = 5;
   localparam int B_CLR   = 4;
   localparam int B_EN    = 3;
   localparam int B_AL    = 3;
   localparam int B_AAS   = 2;
   localparam int B_AD0   = 1;
   localparam int B_LRB   = 0;

   // Soft reset key codes
   localparam logic [1:0] KEY_ARM  = 2'h2;
   localparam logic [1:0] KEY_FIRE = 2'h1;

   // Field widths and reset values
   localparam int PRS_W = 5;
   localparam int SCK_W = 3;
   localparam int IRQ_W = 5;
   localparam logic [PRS_W-1:0] PRS_RST = 5'h00;
   localparam logic [SCK_W-1:0] SCK_RST = 3'h0;
   localparam logic             PIN_RST = 1'b1;

   // Interrupt status bit positions
   localparam int IRQ_XFER  = 0;
   localparam int IRQ_ARB   = 1;
   localparam int IRQ_MATCH = 2;
   localparam int IRQ_START = 3;
   localparam int IRQ_STOP  = 4;

   // Serial clock timing in prescaler ticks: half = 2^(n+1) + base
   localparam logic [5:0] PRS_ZERO_DIV = 6'h20;
   localparam logic [8:0] HIGH_BASE    = 9'h006;
   localparam logic [8:0] LOW_BASE     = 9'h00A;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   function automatic logic [5:0] prs_div(input logic [PRS_W-1:0] code);
      return (code == 5'h00) ? PRS_ZERO_DIV : {1'b0, code};
   endfunction

   function automatic logic [8:0] half_ticks(input logic [SCK_W-1:0] n, input logic low);
      logic [8:0] pow;
      pow = 9'h002 << n;
      return pow + (low ? LOW_BASE : HIGH_BASE);
   endfunction

endpackage

//--- rtl/scl_timer.sv
// Purpose: Times one high or low serial clock half period from the prescaler
// Assumes: Settings stay stable while a period runs
// Notes:   done is high in the last of the prs_div * half_ticks cycles after the load edge
`timescale 1ns/100ps
module scl_timer (
   // Clock and reset
   input  wire logic                             hclk,
   input  wire logic                             hresetn,
   // Divider settings
   input  wire logic [i2c_csp_pkg::PRS_W-1:0]    prs_code,
   input  wire logic [i2c_csp_pkg::SCK_W-1:0]    sck_code,
   // Half period request
   input  wire logic                             load,
   input  wire logic                             use_low,
   output logic                                  done
);
   import i2c_csp_pkg::*;

   logic [5:0] prs_cnt_ff;
   logic [5:0] nxt_prs_cnt;
   logic [8:0] tick_cnt_ff;
   logic [8:0] nxt_tick_cnt;
   logic       run_ff;
   logic       nxt_run;

   // Each tick lasts p system clocks, a half period lasts i or j ticks
   always_comb begin
      nxt_prs_cnt  = prs_cnt_ff;
      nxt_tick_cnt = tick_cnt_ff;
      nxt_run      = run_ff;
      if (load) begin
         nxt_run      = 1'b1;
         nxt_prs_cnt  = prs_div(prs_code) - 6'h01;
         nxt_tick_cnt = half_ticks(sck_code, use_low) - 9'h001;
      end else if (run_ff) begin
         if (prs_cnt_ff != 6'h00) begin
            nxt_prs_cnt = prs_cnt_ff - 6'h01;
         end else if (tick_cnt_ff != 9'h000) begin
            nxt_tick_cnt = tick_cnt_ff - 9'h001;
            nxt_prs_cnt  = prs_div(prs_code) - 6'h01;
         end else begin
            nxt_run  = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prs_cnt_ff  <= 6'h00;
         tick_cnt_ff <= 9'h000;
         run_ff      <= 1'b0;
      end else begin
         prs_cnt_ff  <= nxt_prs_cnt;
         tick_cnt_ff <= nxt_tick_cnt;
         run_ff      <= nxt_run;
      end
   end

   // Decoded from state so the next phase starts on the edge that ends this one
   assign done = run_ff & (prs_cnt_ff == 6'h00) & (tick_cnt_ff == 9'h000);

endmodule

//--- rtl/i2c_ctrl_status.sv
// Purpose: Control/status view, prescaler and start/stop generation of a two-wire bus port
// Assumes: Bus pins and sequencer strobes are synchronous to hclk
// Notes:   Byte level sequencing lives outside; it reports events on the seq_ inputs
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module i2c_ctrl_status (
   // AHB-Lite slave
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic                          hready,
   input  wire logic [31:0]                   hwdata,
   output logic      [31:0]                   hrdata,
   output logic                               hreadyout,
   output logic                               hresp,
   // Serial pins
   input  wire logic                          scl_in,
   output logic                               scl_out,
   output logic                               scl_oe,
   input  wire logic                          sda_in,
   output logic                               sda_out,
   output logic                               sda_oe,
   // Transfer sequencer
   input  wire logic                          seq_xfer_done,
   input  wire logic                          seq_arb_lost,
   input  wire logic                          seq_addr_match,
   input  wire logic                          seq_gen_call,
   input  wire logic [7:0]                    seq_rx_data,
   output logic      [7:0]                    tx_data,
   output logic                               role_select,
   output logic                               direction_select,
   output logic                               interface_enable,
   output logic                               data_release,
   output logic                               soft_reset_pulse,
   // Interrupts
   output logic                               transfer_irq,
   output logic                               irq
);
   import i2c_csp_pkg::*;

   typedef enum logic [2:0] {GEN_IDLE, GEN_START, GEN_OWNED, GEN_STOP_LOW, GEN_STOP_HIGH} gen_state_t;

   logic [7:0]       addr_ff, nxt_addr;
   logic             wr_ff, nxt_wr;
   logic [31:0]      hrdata_ff, nxt_hrdata;
   logic             role_ff, nxt_role;
   logic             dir_ff, nxt_dir;
   logic             en_ff, nxt_en;
   logic             armed_ff, nxt_armed;
   logic             pin_ff, nxt_pin;
   logic             al_ff, nxt_al;
   logic             aas_ff, nxt_aas;
   logic             ad0_ff, nxt_ad0;
   logic [PRS_W-1:0] prs_ff, nxt_prs;
   logic [SCK_W-1:0] sck_ff, nxt_sck;
   logic [7:0]       tx_ff, nxt_tx;
   logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
   logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
   logic             irq_ff, nxt_irq;
   logic             tirq_ff, nxt_tirq;
   logic             release_ff, nxt_release;
   logic             swrst_ff, nxt_swrst;
   logic             scl_q_ff, sda_q_ff;
   logic             busy_ff, nxt_busy;
   logic             lrb_ff, nxt_lrb;
   gen_state_t       gen_ff, nxt_gen;
   logic             scl_oe_ff, nxt_scl_oe;
   logic             sda_oe_ff, nxt_sda_oe;
   logic             timer_load, timer_low, timer_done;

   logic             rd_take, ctrl_wr, soft_rst, start_req, stop_req;
   logic             start_det, stop_det, scl_rise;
   logic [7:0]       status_vec;
   logic [IRQ_W-1:0] events;

   assign rd_take    = hsel & hready & (htrans == HTRANS_NONSEQ) & ~hwrite;
   assign ctrl_wr    = wr_ff & (addr_ff == OFF_CTRL);
   assign soft_rst   = ctrl_wr & armed_ff & (hwdata[1:0] == KEY_FIRE);
   assign start_req  = ctrl_wr & hwdata[B_COND] & hwdata[B_ROLE] & en_ff & ~busy_ff
                       & (gen_ff == GEN_IDLE) & ~soft_rst;
   assign stop_req   = ctrl_wr & ~hwdata[B_COND] & role_ff & (gen_ff == GEN_OWNED);
   assign start_det  = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
   assign stop_det   = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
   assign scl_rise   = scl_in & ~scl_q_ff;
   assign status_vec = {role_ff, dir_ff, busy_ff, pin_ff, al_ff, aas_ff, ad0_ff, lrb_ff};
   assign events     = {stop_det, start_det, seq_addr_match | seq_gen_call, seq_arb_lost, seq_xfer_done};

   // Bus slave and register file
   always_comb begin
      nxt_addr     = addr_ff;
      nxt_wr       = 1'b0;
      nxt_hrdata   = hrdata_ff;
      nxt_role     = role_ff;
      nxt_dir      = dir_ff;
      nxt_en       = en_ff;
      nxt_armed    = armed_ff;
      nxt_pin      = pin_ff;
      nxt_al       = al_ff;
      nxt_aas      = aas_ff;
      nxt_ad0      = ad0_ff;
      nxt_prs      = prs_ff;
      nxt_sck      = sck_ff;
      nxt_tx       = tx_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_irq_stat = irq_stat_ff;
      nxt_release  = 1'b0;
      nxt_swrst    = 1'b0;
      if (hsel & hready & (htrans == HTRANS_NONSEQ)) begin
         nxt_addr = haddr[7:0];
         nxt_wr   = hwrite;
      end
      if (rd_take) begin
         case (haddr[7:0])
            OFF_CTRL:     nxt_hrdata = {24'h000000, status_vec};
            OFF_PRS:      nxt_hrdata = {27'h0000000, prs_ff};
            OFF_SCK:      nxt_hrdata = {29'h00000000, sck_ff};
            OFF_DATA:     nxt_hrdata = {24'h000000, dir_ff ? tx_ff : seq_rx_data};
            OFF_IRQ_STAT: nxt_hrdata = {27'h0000000, irq_stat_ff};
            OFF_IRQ_MASK: nxt_hrdata = {27'h0000000, irq_mask_ff};
            default:      nxt_hrdata = 32'h00000000;
         endcase
         if (haddr[7:0] == OFF_IRQ_STAT) begin
            nxt_irq_stat = '0;
         end
         if ((haddr[7:0] == OFF_DATA) & ~dir_ff) begin
            nxt_pin     = 1'b1;
            nxt_release = 1'b1;
         end
      end
      if (ctrl_wr) begin
         nxt_role  = hwdata[B_ROLE];
         nxt_dir   = hwdata[B_DIR];
         nxt_armed = (hwdata[1:0] == KEY_ARM);
         if (hwdata[B_CLR]) begin
            nxt_pin = 1'b1;
            nxt_al  = 1'b0;
            nxt_aas = 1'b0;
            nxt_ad0 = 1'b0;
         end
         if (hwdata[B_EN] | ~busy_ff) begin
            nxt_en = hwdata[B_EN];
         end
         if (soft_rst) begin
            nxt_role  = 1'b0;
            nxt_dir   = 1'b0;
            nxt_pin   = PIN_RST;
            nxt_al    = 1'b0;
            nxt_aas   = 1'b0;
            nxt_ad0   = 1'b0;
            nxt_swrst = 1'b1;
         end
      end
      if (wr_ff) begin
         case (addr_ff)
            OFF_PRS:      nxt_prs = hwdata[PRS_W-1:0];
            OFF_SCK:      nxt_sck = hwdata[SCK_W-1:0];
            OFF_IRQ_MASK: nxt_irq_mask = hwdata[IRQ_W-1:0];
            OFF_DATA: begin
               nxt_tx = hwdata[7:0];
               if (dir_ff) begin
                  nxt_pin     = 1'b1;
                  nxt_release = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Hardware events win over any clear in the same cycle
      if (seq_xfer_done) nxt_pin = 1'b0;
      if (seq_arb_lost) nxt_al = 1'b1;
      if (seq_addr_match | seq_gen_call) nxt_aas = 1'b1;
      if (seq_gen_call) nxt_ad0 = 1'b1;
      nxt_irq_stat = nxt_irq_stat | events;
      nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
      nxt_tirq     = ~nxt_pin;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ff     <= 8'h00;
         wr_ff       <= 1'b0;
         hrdata_ff   <= 32'h00000000;
         role_ff     <= 1'b0;
         dir_ff      <= 1'b0;
         en_ff       <= 1'b0;
         armed_ff    <= 1'b0;
         pin_ff      <= PIN_RST;
         al_ff       <= 1'b0;
         aas_ff      <= 1'b0;
         ad0_ff      <= 1'b0;
         prs_ff      <= PRS_RST;
         sck_ff      <= SCK_RST;
         tx_ff       <= 8'h00;
         irq_stat_ff <= '0;
         irq_mask_ff <= '0;
         irq_ff      <= 1'b0;
         tirq_ff     <= 1'b0;
         release_ff  <= 1'b0;
         swrst_ff    <= 1'b0;
      end else begin
         addr_ff     <= nxt_addr;
         wr_ff       <= nxt_wr;
         hrdata_ff   <= nxt_hrdata;
         role_ff     <= nxt_role;
         dir_ff      <= nxt_dir;
         en_ff       <= nxt_en;
         armed_ff    <= nxt_armed;
         pin_ff      <= nxt_pin;
         al_ff       <= nxt_al;
         aas_ff      <= nxt_aas;
         ad0_ff      <= nxt_ad0;
         prs_ff      <= nxt_prs;
         sck_ff      <= nxt_sck;
         tx_ff       <= nxt_tx;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         irq_ff      <= nxt_irq;
         tirq_ff     <= nxt_tirq;
         release_ff  <= nxt_release;
         swrst_ff    <= nxt_swrst;
      end
   end

   // Bus monitor and start/stop generator
   always_comb begin
      nxt_busy   = busy_ff;
      nxt_lrb    = lrb_ff;
      nxt_gen    = gen_ff;
      timer_load = 1'b0;
      timer_low  = 1'b0;
      if (start_det) nxt_busy = 1'b1;
      if (stop_det) nxt_busy = 1'b0;
      if (scl_rise) nxt_lrb = sda_in;
      case (gen_ff)
         GEN_IDLE: begin
            if (start_req) begin
               nxt_gen    = GEN_START;
               timer_load = 1'b1;
            end
         end
         GEN_START: begin
            if (timer_done) nxt_gen = GEN_OWNED;
         end
         GEN_OWNED: begin
            if (stop_req) begin
               nxt_gen    = GEN_STOP_LOW;
               timer_load = 1'b1;
               timer_low  = 1'b1;
            end
         end
         GEN_STOP_LOW: begin
            if (timer_done) begin
               nxt_gen    = GEN_STOP_HIGH;
               timer_load = 1'b1;
            end
         end
         GEN_STOP_HIGH: begin
            if (timer_done) nxt_gen = GEN_IDLE;
         end
         default: nxt_gen = GEN_IDLE;
      endcase
      // Losing the bus, disabling or soft reset drops the pins at once
      if (seq_arb_lost | ~en_ff | soft_rst) nxt_gen = GEN_IDLE;
      nxt_sda_oe = (nxt_gen == GEN_START) | (nxt_gen == GEN_STOP_LOW) | (nxt_gen == GEN_STOP_HIGH);
      nxt_scl_oe = (nxt_gen == GEN_OWNED) | (nxt_gen == GEN_STOP_LOW);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_q_ff  <= 1'b1;
         sda_q_ff  <= 1'b1;
         busy_ff   <= 1'b0;
         lrb_ff    <= 1'b0;
         gen_ff    <= GEN_IDLE;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else begin
         scl_q_ff  <= scl_in;
         sda_q_ff  <= sda_in;
         busy_ff   <= nxt_busy;
         lrb_ff    <= nxt_lrb;
         gen_ff    <= nxt_gen;
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
      end
   end

   scl_timer u_timer (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .prs_code (prs_ff),
      .sck_code (sck_ff),
      .load     (timer_load),
      .use_low  (timer_low),
      .done     (timer_done)
   );

   assign hrdata           = hrdata_ff;
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign scl_out          = 1'b0;
   assign sda_out          = 1'b0;
   assign scl_oe           = scl_oe_ff;
   assign sda_oe           = sda_oe_ff;
   assign tx_data          = tx_ff;
   assign role_select      = role_ff;
   assign direction_select = dir_ff;
   assign interface_enable = en_ff;
   assign data_release     = release_ff;
   assign soft_reset_pulse = swrst_ff;
   assign transfer_irq     = tirq_ff;
   assign irq              = irq_ff;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   status_read_a: assert property (rd_take && haddr[7:0] == OFF_CTRL |=> hrdata == {24'h000000, $past(status_vec)})
      else $error("status view read mismatch");
   role_dir_a: assert property (ctrl_wr && !soft_rst |=> role_ff == $past(hwdata[B_ROLE]) && dir_ff == $past(hwdata[B_DIR]))
      else $error("role or direction not taken");
   start_gen_a: assert property (start_req && !seq_arb_lost |=> (sda_oe && !scl_oe)[*2])
      else $error("start condition not driven");
   pin_clear_a: assert property (ctrl_wr && hwdata[B_CLR] && !seq_xfer_done |=> pin_ff && !transfer_irq)
      else $error("interrupt request not withdrawn");
   en_hold_a: assert property (ctrl_wr && busy_ff && en_ff && !hwdata[B_EN] |=> en_ff)
      else $error("enable cleared while busy");
   soft_rst_a: assert property (soft_rst && !seq_xfer_done |=> soft_reset_pulse && !role_ff && pin_ff)
      else $error("soft reset not applied");
   key_order_a: assert property (ctrl_wr && !armed_ff |=> !soft_reset_pulse)
      else $error("soft reset without arming");
   bus_busy_a: assert property (start_det |=> busy_ff)
      else $error("busy flag not set by start");
   bus_free_a: assert property (stop_det |=> !busy_ff)
      else $error("busy flag not cleared by stop");
   pending_a: assert property (seq_xfer_done |=> !pin_ff && transfer_irq)
      else $error("transfer event did not raise request");
   gen_call_a: assert property (seq_gen_call |=> aas_ff && ad0_ff)
      else $error("general call flags not set");
   last_bit_a: assert property (scl_rise |=> lrb_ff == $past(sda_in))
      else $error("last bit not captured");
   prs_write_a: assert property (wr_ff && addr_ff == OFF_PRS |=> prs_ff == $past(hwdata[PRS_W-1:0]))
      else $error("prescaler not written");
   data_release_a: assert property (wr_ff && addr_ff == OFF_DATA && dir_ff && !seq_xfer_done |=> pin_ff && data_release)
      else $error("data write did not release");

   start_seen_c: cover property (start_req ##[1:1000] gen_ff == GEN_OWNED);
   soft_rst_c: cover property (soft_rst);
   irq_c: cover property ($rose(irq));

endmodule

//--- sim/bus_peer.sv
// Purpose: Other devices on the two-wire bus: pull-ups plus a second master
// Assumes: Pins resolve as wired-and with pull-ups; design oe high drives its out level
// Notes:   Peer changes its lines just after a rising edge
`timescale 1ns/100ps
module bus_peer (
   // Clock
   input  wire logic hclk,
   // Design pin drives
   input  wire logic scl_out,
   input  wire logic scl_oe,
   input  wire logic sda_out,
   input  wire logic sda_oe,
   // Resolved pin levels
   output logic      scl_in,
   output logic      sda_in
);
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;

   // Released lines float to the pull-up level
   assign scl_in = !scl_low & !(scl_oe & !scl_out);
   assign sda_in = !sda_low & !(sda_oe & !sda_out);

   task automatic hold(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Start: SDA falls while SCL is high, then SCL is held low
   task automatic bus_start();
      @(posedge hclk) sda_low <= 1'b1;
      hold(4);
      scl_low <= 1'b1;
   endtask

   // One bit: data set while SCL is low, sampled on the SCL rise
   task automatic send_bit(input logic b);
      @(posedge hclk) sda_low <= !b;
      hold(4);
      scl_low <= 1'b0;
      hold(4);
      scl_low <= 1'b1;
   endtask

   // Stop: SDA rises while SCL is high, leaving both lines free
   task automatic bus_stop();
      @(posedge hclk) sda_low <= 1'b1;
      hold(4);
      scl_low <= 1'b0;
      hold(4);
      sda_low <= 1'b0;
      hold(4);
   endtask
endmodule

//--- sim/i2c_control_status_prescaler_test.sv
// Purpose: Self-checking bench of the control, status and prescaler block
// Assumes: Zero wait state slave, hready looped from hreadyout
// Notes:   A reference model of the status view is updated beside each stimulus
`timescale 1ns/100ps
`define CHK(n, e, g) check_val(n, 32'(e), 32'(g));
module i2c_control_status_prescaler_test;
   import i2c_csp_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, seq_xfer_done = 1'b0, seq_arb_lost = 1'b0;
   logic seq_addr_match = 1'b0, seq_gen_call = 1'b0, role_select, direction_select;
   logic interface_enable, data_release, soft_reset_pulse, transfer_irq, irq;
   logic [7:0] seq_rx_data = 8'h00, tx_data;
   logic [31:0] keys [4] = '{32'hC9, 32'hCA, 32'hCB, 32'hC9};
   int miscompares = 0, checked = 0, seed = 737, cyc = 0, resets = 0, releases = 0, cnt, p, d;
   int role = 0, dir = 0, busy = 0, pin = 1, al = 0, address_match_flag = 0, ad0 = 0, last_bit_flag = 0;

   i2c_ctrl_status i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .scl_in, .scl_out, .scl_oe,
      .sda_in, .sda_out, .sda_oe, .seq_xfer_done, .seq_arb_lost, .seq_addr_match, .seq_gen_call,
      .seq_rx_data, .tx_data, .role_select, .direction_select, .interface_enable, .data_release,
      .soft_reset_pulse, .transfer_irq, .irq);
   bus_peer i_peer (.hclk, .scl_out, .scl_oe, .sda_out, .sda_oe, .scl_in, .sda_in);

   initial forever #25 hclk = !hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (soft_reset_pulse === 1'b1) resets <= resets + 1;
      if (data_release === 1'b1) releases <= releases + 1;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic [31:0] exp_st();
      return {24'h0, 1'(role), 1'(dir), 1'(busy), 1'(pin), 1'(al), 1'(address_match_flag), 1'(ad0), 1'(last_bit_flag)};
   endfunction

   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic chk_st(input string n);
      ahb(1'b0, OFF_CTRL, 0);
      `CHK(n, exp_st(), rd)
      `CHK("okay resp", 0, hresp)
   endtask

   task automatic pulse(input logic [3:0] v);
      @(posedge hclk) {seq_gen_call, seq_addr_match, seq_arb_lost, seq_xfer_done} <= v;
      @(posedge hclk) {seq_gen_call, seq_addr_match, seq_arb_lost, seq_xfer_done} <= 4'h0;
   endtask

   task automatic wait_cnt(input logic a);
      cnt = 0;
      while ((a ? scl_oe !== 1'b1 : (scl_oe | sda_oe) !== 1'b0) && cnt < 2000) begin
         @(posedge hclk);
         #1 cnt++;
      end
   endtask

   task automatic print_verdict();
      $display("counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      chk_st("reset status");
      ahb(1'b0, OFF_PRS, 0);
      `CHK("prs reset", PRS_RST, rd)
      ahb(1'b0, 32'h18, 0);
      `CHK("unmapped", 0, rd)
      `CHK("irq reset", 0, transfer_irq)
      d = $random(seed);
      ahb(1'b1, OFF_PRS, d);
      ahb(1'b0, OFF_PRS, 0);
      `CHK("prs rw", d & 32'h1F, rd)
      $display("test registers done");
      ahb(1'b1, OFF_CTRL, 32'hC8);
      role = 1; dir = 1;
      chk_st("role dir");
      `CHK("mode pins", 2'h3, {role_select, direction_select})
      `CHK("enable", 1, interface_enable)
      ahb(1'b1, OFF_IRQ_MASK, 32'h1);
      pulse(4'h1); pin = 0;
      chk_st("pending");
      `CHK("xfer irq", 1, transfer_irq)
      `CHK("irq out", 1, irq)
      ahb(1'b1, OFF_CTRL, 32'hC8);
      chk_st("clear zero");
      ahb(1'b1, OFF_CTRL, 32'hD8); pin = 1;
      chk_st("clear one");
      `CHK("xfer irq off", 0, transfer_irq)
      ahb(1'b0, OFF_IRQ_STAT, 0);
      `CHK("irq stat", 1, rd)
      `CHK("irq cleared", 0, irq)
      pulse(4'hA); al = 1; address_match_flag = 1; ad0 = 1;
      chk_st("flags");
      `CHK("irq masked", 0, irq)
      ahb(1'b1, OFF_CTRL, 32'hD8); al = 0; address_match_flag = 0; ad0 = 0;
      pulse(4'h1); pin = 0;
      d = $random(seed) & 8'hFF;
      ahb(1'b1, OFF_DATA, d); pin = 1;
      chk_st("data release");
      `CHK("tx data", d, tx_data)
      `CHK("release pulse", 1, releases)
      $display("test events done");
      i_peer.bus_start(); busy = 1;
      repeat (2) @(posedge hclk);
      chk_st("peer busy");
      repeat (2) begin
         last_bit_flag = $random(seed) & 1;
         i_peer.send_bit(last_bit_flag[0]);
         chk_st("last bit");
      end
      i_peer.bus_stop(); busy = 0; last_bit_flag = 0;
      chk_st("peer free");
      $display("test peer done");
      for (int i = 0; i < 2; i++) begin
         ahb(1'b1, OFF_PRS, i * 3);
         ahb(1'b1, OFF_SCK, i);
         ahb(1'b1, OFF_CTRL, 32'hE8);
         wait_cnt(1'b1);
         p = (i == 0) ? 32 : 3;
         `CHK("start hold", p * ((2 << i) + 6), cnt)
         busy = 1;
         chk_st("own busy");
         ahb(1'b1, OFF_CTRL, 32'hE0);
         `CHK("enable kept", 1, interface_enable)
         ahb(1'b1, OFF_CTRL, 32'hC8);
         wait_cnt(1'b0);
         `CHK("stop time", p * ((4 << i) + 16), cnt)
         repeat (3) @(posedge hclk);
         busy = 0;
         chk_st("stopped");
      end
      $display("test master done");
      foreach (keys[k]) ahb(1'b1, OFF_CTRL, keys[k]);
      `CHK("no reset", 0, resets)
      ahb(1'b1, OFF_CTRL, 32'hCA);
      ahb(1'b1, OFF_CTRL, 32'hC9);
      repeat (2) @(posedge hclk);
      `CHK("soft reset", 1, resets)
      role = 0; dir = 0;
      chk_st("after reset");
      $display("test soft reset done");
      print_verdict();
   end
endmodule
